/* File: rtl/wstr_pkg.sv */
/*
 * constants for the temperature, revision and wheel-output test registers.
 * assumes a plain register port of 20-bit registers at word indices.
 */
package wstr_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          REG_W        = 20;
  localparam logic [3:0]  OFS_STATIC   = 4'h2;   // wheel_output_static_test
  localparam logic [3:0]  OFS_CFG12    = 4'h3;   // wheel_channel_1_2_config
  localparam logic [3:0]  OFS_STATUS   = 4'hD;   // temperature_and_revision_status
  localparam logic [3:0]  OFS_IRQ_STAT = 4'hE;   // sticky event bits
  localparam logic [3:0]  OFS_IRQ_MASK = 4'hF;   // event enables
  // ****************************************************************
  // status field positions
  // ****************************************************************
  localparam int MAJ_LSB  = 15;
  localparam int MIN_LSB  = 12;
  localparam int WDM_BIT  = 11;
  localparam int GNDD_BIT = 10;
  localparam int GNDA_BIT = 9;
  localparam int OTMP_BIT = 8;
  // ****************************************************************
  // static test fields and select codes
  // ****************************************************************
  localparam int         SEL_LSB  = 2;
  localparam int         SEL_W    = 7;
  localparam logic [6:0] SEL_OUT4 = 7'h53;  // 1010011
  localparam logic [6:0] SEL_OUT3 = 7'h55;  // 1010101
  localparam logic [6:0] SEL_OUT2 = 7'h59;  // 1011001
  localparam logic [6:0] SEL_OUT1 = 7'h56;  // 1010110
  localparam logic [19:0] STATIC_MASK = 20'h001FD;
  // ****************************************************************
  // channel configuration: two 10-bit fields, bit 2 of each unused
  // ****************************************************************
  localparam int          CH_W      = 10;
  localparam int          CH2_LSB   = 10;
  localparam int          STS_LSB   = 0;
  localparam int          FIX_BIT   = 3;
  localparam int          SSD_BIT   = 4;
  localparam int          PTE_BIT   = 5;
  localparam int          FLT_LSB   = 6;
  localparam logic [19:0] CFG_MASK  = 20'hFEFFB;  // bits 2 and 12 unused
  // ****************************************************************
  // interrupt bits and timing of the filter
  // ****************************************************************
  localparam int          EV_GNDD  = 0;
  localparam int          EV_GNDA  = 1;
  localparam int          EV_OTMP  = 2;
  localparam logic [2:0]  EV_MASK  = 3'h7;
  localparam int          FILT_BASE_NS = 8000;
  localparam int          FILT_STEP_NS = 500;
  localparam int          CLK_NS       = 25;
  localparam int          TEMP_OFS_C   = 85;
  localparam int          TEMP_SPAN_C  = 305;
endpackage : wstr_pkg

/* File: rtl/wstr_regs.sv */
/*
 * status and test register group: status word, static output test,
 * channel 1/2 configuration and a small interrupt block.
 * assumes synchronous inputs and a host that reads in one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - major revision is a 3-bit strap counter, cleared only by power-on.
// - minor revision is a 3-bit strap counter, cleared only by power-on.
// - ground-loss self-test flags, 1 failed, clear on read/undervoltage/loss.
// - internal overtemperature flag, clear on read/undervoltage/loss/power-on.
// - 8-bit die temperature code, host converts N/255*305-85, power-on reset.
// - in static test the selected wheel output follows the inverted test bit.
// - select codes 1010011, 1010101, 1011001 pick outputs 4, 3, 2.
// - code 1010110 picks output 1; any other code disables the test.
// - test bit drives the output inverted: 0 high, 1 low.
// - test fields reset on undervoltage, ground loss, power-on; not reads.
// - each wheel channel uses its own 10-bit field, two per register.
// - 2-bit sensor type: standard, three-level, PWM two-edge, PWM one-edge.
// - 4-bit filter code sets 8 us plus 500 ns per step.
// - pass-through, standstill disable and fixed threshold bits per channel.
module wstr_regs
  import wstr_pkg::*;
#(
  parameter int NCH = 4
) (
  // clock and resets
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           batteryUndervoltageEvent,
  input  wire logic           groundLossEvent,
  // register port
  input  wire logic [3:0]     regAddr,
  input  wire logic [19:0]    regWdata,
  input  wire logic           regWr,
  input  wire logic           regRd,
  output logic      [19:0]    regRdata,
  // device state to report
  input  wire logic [2:0]     majorRevisionStrap,
  input  wire logic [2:0]     minorRevisionStrap,
  input  wire logic           watchdogDisableMirror,
  input  wire logic           gndDigitalFail,
  input  wire logic           gndAnalogFail,
  input  wire logic           internalOvertempFlag,
  input  wire logic [7:0]     dieTempCode,
  // wheel outputs
  input  wire logic [NCH-1:0] wheelNormalOut,
  output logic      [NCH-1:0] wheelDigitalOutput,
  // channel configuration
  output logic      [1:0]     sensorTypeSelect [2],
  output logic      [3:0]     inputFilterTime [2],
  output logic      [9:0]     filterCycles [2],
  output logic      [1:0]     passThroughEnable,
  output logic      [1:0]     standstillOutputDisable,
  output logic      [1:0]     fixedThresholdSelect,
  // interrupt
  output logic                irq
);
  // ****************************************************************
  // decode
  // ****************************************************************
  wire logic softRst   = batteryUndervoltageEvent | groundLossEvent;
  wire logic hitStatic = regAddr == OFS_STATIC;
  wire logic hitCfg    = regAddr == OFS_CFG12;
  wire logic hitStatus = regAddr == OFS_STATUS;
  wire logic hitIstat  = regAddr == OFS_IRQ_STAT;
  wire logic hitImask  = regAddr == OFS_IRQ_MASK;
  wire logic rdStatus  = regRd & hitStatus;

  logic [2:0]  majRev_q, minRev_q;
  logic        strapTaken_q;
  logic        wdMirror_q, gndD_q, gndA_q, oTmp_q;
  logic [7:0]  temp_q;
  logic [19:0] static_q, cfg_q;
  logic [2:0]  iStat_q, iMask_q;

  // revision counters caught once after power-on release
  always_ff @(posedge clk) begin
    if (rst) begin
      majRev_q     <= 3'h0;
      minRev_q     <= 3'h0;
      strapTaken_q <= 1'b0;
    end else if (!strapTaken_q) begin
      majRev_q     <= majorRevisionStrap;
      minRev_q     <= minorRevisionStrap;
      strapTaken_q <= 1'b1;
    end
  end

  // temperature code and watchdog mirror: power-on reset only
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_q     <= 8'h00;
      wdMirror_q <= 1'b0;
    end else begin
      temp_q     <= dieTempCode;
      wdMirror_q <= watchdogDisableMirror;
    end
  end

  // self-test flags: set wins over read clear
  always_ff @(posedge clk) begin
    if (rst || softRst) begin
      gndD_q <= 1'b0;
      gndA_q <= 1'b0;
      oTmp_q <= 1'b0;
    end else begin
      gndD_q <= gndDigitalFail | (gndD_q & ~rdStatus);
      gndA_q <= gndAnalogFail | (gndA_q & ~rdStatus);
      oTmp_q <= internalOvertempFlag | (oTmp_q & ~rdStatus);
    end
  end

  // writable registers, unused bits masked off
  always_ff @(posedge clk) begin
    if (rst || softRst) begin
      static_q <= 20'h00000;
      cfg_q    <= 20'h00000;
    end else if (regWr) begin
      if (hitStatic)
        static_q <= regWdata & STATIC_MASK;
      if (hitCfg)
        cfg_q <= regWdata & CFG_MASK;
    end
  end

  // ****************************************************************
  // interrupts: events set sticky bits, write one clears
  // ****************************************************************
  wire logic [2:0] evts = {internalOvertempFlag, gndAnalogFail,
                           gndDigitalFail};
  wire logic [2:0] w1c  = (regWr & hitIstat) ? regWdata[2:0] : 3'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      iStat_q <= 3'h0;
      iMask_q <= 3'h0;
    end else begin
      iStat_q <= evts | (iStat_q & ~w1c);
      if (regWr && hitImask)
        iMask_q <= regWdata[2:0] & EV_MASK;
    end
  end
  assign irq = |(iStat_q & iMask_q);

  // ****************************************************************
  // static output test
  // ****************************************************************
  wire logic [6:0] sel     = static_q[SEL_LSB +: SEL_W];
  wire logic       testLvl = ~static_q[0];
  wire logic [3:0] selHot  = {sel == SEL_OUT4, sel == SEL_OUT3,
                              sel == SEL_OUT2, sel == SEL_OUT1};
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_out
      always_ff @(posedge clk) begin
        if (rst)
          wheelDigitalOutput[gi] <= 1'b0;
        else if (gi < 4 && selHot[gi % 4])
          wheelDigitalOutput[gi] <= testLvl;
        else
          wheelDigitalOutput[gi] <= wheelNormalOut[gi];
      end
    end
  endgenerate

  // ****************************************************************
  // channel fields; filter time in clock cycles (rounded up)
  // ****************************************************************
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      wire logic [9:0] fld = cfg_q[gi*CH2_LSB +: CH_W];
      assign sensorTypeSelect[gi]        = fld[STS_LSB +: 2];
      assign inputFilterTime[gi]         = fld[FLT_LSB +: 4];
      assign passThroughEnable[gi]       = fld[PTE_BIT];
      assign standstillOutputDisable[gi] = fld[SSD_BIT];
      assign fixedThresholdSelect[gi]    = fld[FIX_BIT];
      assign filterCycles[gi] = 10'((FILT_BASE_NS + CLK_NS - 1
                                + FILT_STEP_NS * int'(fld[FLT_LSB +: 4]))
                                / CLK_NS);
    end
  endgenerate

  // ****************************************************************
  // read mux, data one cycle after strobe
  // ****************************************************************
  wire logic [19:0] statusWord = {2'h0, majRev_q, minRev_q, wdMirror_q,
                                  gndD_q, gndA_q, oTmp_q, temp_q};
  wire logic [19:0] rdMux =
      hitStatus ? statusWord :
      hitStatic ? static_q :
      hitCfg    ? cfg_q :
      hitIstat  ? {17'h0, iStat_q} :
      hitImask  ? {17'h0, iMask_q} : 20'h00000;
  always_ff @(posedge clk) begin
    if (rst)
      regRdata <= 20'h00000;
    else
      regRdata <= regRd ? rdMux : 20'h00000;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_rev_hold;
    @(posedge clk) disable iff (rst)
      strapTaken_q |=> $stable(majRev_q) && $stable(minRev_q);
  endproperty
  a_rev_hold: assert property (p_rev_hold)
    else $error("revision changed after capture");
  property p_minor_cap;
    @(posedge clk) disable iff (rst)
      !rst && !strapTaken_q |=> minRev_q == $past(minorRevisionStrap);
  endproperty
  a_minor_cap: assert property (p_minor_cap)
    else $error("minor revision not captured");
  property p_gnd_clear;
    @(posedge clk) disable iff (rst)
      rdStatus && !gndDigitalFail && !softRst |=> !gndD_q;
  endproperty
  a_gnd_clear: assert property (p_gnd_clear)
    else $error("ground flag survived read");
  property p_otmp_set;
    @(posedge clk) disable iff (rst)
      !rst && internalOvertempFlag && !softRst |=> oTmp_q;
  endproperty
  a_otmp_set: assert property (p_otmp_set)
    else $error("overtemp event lost");
  property p_temp;
    @(posedge clk) disable iff (rst)
      !rst |=> temp_q == $past(dieTempCode);
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature code not tracked");
  property p_test_out1;
    @(posedge clk) disable iff (rst)
      !rst && sel == SEL_OUT1 |=>
        wheelDigitalOutput[0] == $past(~static_q[0]);
  endproperty
  a_test_out1: assert property (p_test_out1)
    else $error("output 1 not forced inverted");
  property p_test_out4;
    @(posedge clk) disable iff (rst)
      !rst && sel == SEL_OUT4 |=> wheelDigitalOutput[3] == $past(testLvl);
  endproperty
  a_test_out4: assert property (p_test_out4)
    else $error("output 4 not forced");
  property p_no_test;
    @(posedge clk) disable iff (rst)
      !rst && selHot == 4'h0 |=>
        wheelDigitalOutput == $past(wheelNormalOut);
  endproperty
  a_no_test: assert property (p_no_test)
    else $error("normal output overridden");
  property p_soft_rst;
    @(posedge clk) disable iff (rst)
      softRst |=> static_q == 20'h00000 && cfg_q == 20'h00000;
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("test fields not reset");
  property p_unused;
    @(posedge clk) disable iff (rst)
      1'b1 |-> (static_q & ~STATIC_MASK) == 20'h0 && !cfg_q[2] && !cfg_q[12];
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused bit set");
  // remaining forced outputs; the reset edge itself is excluded
  property p_test_out2;
    @(posedge clk) disable iff (rst)
      !rst && sel == SEL_OUT2 |=> wheelDigitalOutput[1] == $past(testLvl);
  endproperty
  a_test_out2: assert property (p_test_out2)
    else $error("output 2 not forced");
  property p_test_out3;
    @(posedge clk) disable iff (rst)
      !rst && sel == SEL_OUT3 |=> wheelDigitalOutput[2] == $past(testLvl);
  endproperty
  a_test_out3: assert property (p_test_out3)
    else $error("output 3 not forced");
  // unmapped indices answer with zero
  property p_unmapped;
    @(posedge clk) disable iff (rst)
      !rst && regRd && !(hitStatic || hitCfg || hitStatus || hitIstat
                         || hitImask) |=> regRdata == 20'h00000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  // static test register only moves on a write or a reset event
  property p_static_hold;
    @(posedge clk) disable iff (rst)
      !rst && !softRst && !regWr |=> $stable(static_q);
  endproperty
  a_static_hold: assert property (p_static_hold)
    else $error("static test register changed without write");
  property p_gnda_set;
    @(posedge clk) disable iff (rst)
      !rst && gndAnalogFail && !softRst |=> gndA_q;
  endproperty
  a_gnda_set: assert property (p_gnda_set)
    else $error("analog ground event lost");
  property p_major_cap;
    @(posedge clk) disable iff (rst)
      !rst && !strapTaken_q |=> majRev_q == $past(majorRevisionStrap);
  endproperty
  a_major_cap: assert property (p_major_cap)
    else $error("major revision not captured");
  // main scenarios seen at least once
  c_test4: cover property (@(posedge clk) sel == SEL_OUT4);
  c_rdclr: cover property (@(posedge clk) rdStatus && gndD_q);
  c_irq:   cover property (@(posedge clk) irq);
  c_soft:  cover property (@(posedge clk) softRst && static_q != 20'h0);
  c_test1: cover property (@(posedge clk) sel == SEL_OUT1 && static_q[0]);
endmodule : wstr_regs
`default_nettype wire

/* File: bench/wstr_host.sv */
/*
 * host model: issues register writes and reads on the plain port.
 * assumes one clock and a slave whose read data stand one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module wstr_host (
  // clock
  input  wire logic        clk,
  // register port
  output logic      [3:0]  regAddr,
  output logic      [19:0] regWdata,
  output logic             regWr,
  output logic             regRd,
  input  wire logic [19:0] regRdata
);
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // idle bus at time zero
  initial begin
    regAddr  = 4'h0;
    regWdata = 20'h00000;
    regWr    = 1'b0;
    regRd    = 1'b0;
  end

  // one-cycle write; released lines show the inverse, never stale data
  task automatic wr(input logic [3:0] a, input logic [19:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask : wr

  // one-cycle read; data are taken mid-cycle, the only cycle they stand
  task automatic rd(input logic [3:0] a, output logic [19:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    regAddr <= ~a;
    @(negedge clk);
    d = regRdata;
  endtask : rd
endmodule : wstr_host
`default_nettype wire

/* File: bench/temp_id_and_wheel_sensor_test_regs_test.sv */
/*
 * bench: register-level tests of the status and wheel-output test block.
 * assumes wstr_host drives the register port; 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module temp_id_and_wheel_sensor_test_regs_test
  import wstr_pkg::*;
;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic        clk, rst, wdm, irq, regWr, regRd;
  logic [4:0]  ev;  // gndD, gndA, overtemp, undervoltage, ground loss
  logic [2:0]  majS, minS;
  logic [7:0]  temp;
  logic [3:0]  normOut, wheelOut, regAddr, e4;
  logic [19:0] regWdata, regRdata, rdv, base;
  logic [1:0]  sts [2];
  logic [3:0]  flt [2];
  logic [9:0]  cyc [2], f [2];
  logic [1:0]  pte, ssd, fix;
  logic [6:0]  codes [4];
  int          failures = 0, nCompared = 0, cycles = 0;

  wstr_regs u_wstr_regs (
    .clk(clk), .rst(rst), .batteryUndervoltageEvent(ev[3]),
    .groundLossEvent(ev[4]), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .majorRevisionStrap(majS), .minorRevisionStrap(minS),
    .watchdogDisableMirror(wdm), .gndDigitalFail(ev[0]),
    .gndAnalogFail(ev[1]), .internalOvertempFlag(ev[2]),
    .dieTempCode(temp), .wheelNormalOut(normOut),
    .wheelDigitalOutput(wheelOut), .sensorTypeSelect(sts),
    .inputFilterTime(flt), .filterCycles(cyc), .passThroughEnable(pte),
    .standstillOutputDisable(ssd), .fixedThresholdSelect(fix), .irq(irq));
  wstr_host u_wstr_host (.clk(clk), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

  // 25 ns clock and a hang limit
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ****************************************************************
  // compare and stimulus tasks
  // ****************************************************************
  task automatic chkReg(input logic [3:0] a, input logic [19:0] e);
    logic [19:0] d;
    u_wstr_host.rd(a, d);
    nCompared++;
    if (d !== e) begin
      failures++;
      $display("Error at %0t: reg %h read %h expected %h", $time, a, d, e);
    end
  endtask : chkReg

  task automatic chkPort(input logic [19:0] g, input logic [19:0] e);
    nCompared++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: port value %h expected %h", $time, g, e);
    end
  endtask : chkPort

  // one-cycle event pulse
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev    <= 5'h00;
  endtask : pulse

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    ev = 5'h00;
    majS = 3'h5;
    minS = 3'h2;
    wdm = 1'b1;
    temp = 8'hA7;
    normOut = 4'hA;
    codes = '{SEL_OUT1, SEL_OUT2, SEL_OUT3, SEL_OUT4};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    majS <= 3'h1;  // straps move after capture
    minS <= 3'h6;
    chkReg(OFS_STATUS, 20'h2A8A7);
    chkReg(OFS_STATIC, 20'h00000);
    chkReg(OFS_CFG12, 20'h00000);
    chkPort(20'(wheelOut), 20'(normOut));
    u_wstr_host.wr(4'h5, 20'hFFFFF);
    chkReg(4'h5, 20'h00000);
    u_wstr_host.wr(OFS_STATUS, 20'hFFFFF);
    temp <= 8'h3C;
    wdm <= 1'b0;
    pulse(3);
    base = {2'b00, 3'h5, 3'h2, 1'b0, 3'h0, 8'h3C};
    chkReg(OFS_STATUS, base);
    // flags: set, clear on read, clear on undervoltage or ground loss
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      chkReg(OFS_STATUS, base | (20'h00400 >> i));
      chkReg(OFS_STATUS, base);
      pulse(i);
      pulse(3 + i % 2);
      chkReg(OFS_STATUS, base);
    end
    // interrupt: sticky, masked, cleared by writing one
    chkReg(OFS_IRQ_STAT, 20'h00007);
    chkPort(20'(irq), 20'h00000);
    u_wstr_host.wr(OFS_IRQ_MASK, 20'h00002);
    chkReg(OFS_IRQ_MASK, 20'h00002);
    chkPort(20'(irq), 20'h00001);
    u_wstr_host.wr(OFS_IRQ_STAT, 20'h00002);
    chkReg(OFS_IRQ_STAT, 20'h00005);
    chkPort(20'(irq), 20'h00000);
    // static test on every output with both test levels
    for (int k = 0; k < 4; k++) begin
      for (int t = 0; t < 2; t++) begin
        @(posedge clk);
        normOut <= ~normOut;
        rdv = {11'h000, codes[k], 1'b0, t[0]};
        u_wstr_host.wr(OFS_STATIC, rdv);
        chkReg(OFS_STATIC, rdv);
        e4 = normOut;
        e4[k] = ~t[0];
        chkPort(20'(wheelOut), 20'(e4));
      end
    end
    // undefined codes disable the test; a ground-loss event clears the register
    for (int k = 0; k < 2; k++) begin
      u_wstr_host.wr(OFS_STATIC, k ? 20'h0015C : 20'hFFFFF);
      chkReg(OFS_STATIC, k ? 20'h0015C : 20'h001FD);
      chkPort(20'(wheelOut), 20'(normOut));
    end
    u_wstr_host.wr(OFS_STATIC, {11'h000, SEL_OUT2, 2'b01});
    pulse(4);
    chkReg(OFS_STATIC, 20'h00000);
    chkPort(20'(wheelOut), 20'(normOut));
    // channel configuration fields and decoded outputs
    u_wstr_host.wr(OFS_CFG12, 20'hFFFFF);
    chkReg(OFS_CFG12, 20'hFEFFB);
    for (int i = 0; i < 4; i++) begin
      f[0] = {4'(5 * i), i[0], i[1], ~i[0], 1'b0, 2'(i)};
      f[1] = {4'(15 - 5 * i), ~i[1], i[0], i[1], 1'b0, 2'(3 - i)};
      u_wstr_host.wr(OFS_CFG12, {f[1], f[0]});
      chkReg(OFS_CFG12, {f[1], f[0]});
      for (int c = 0; c < 2; c++) begin
        chkPort(20'(sts[c]), 20'(f[c][1:0]));
        chkPort(20'(fix[c]), 20'(f[c][3]));
        chkPort(20'(ssd[c]), 20'(f[c][4]));
        chkPort(20'(pte[c]), 20'(f[c][5]));
        chkPort(20'(flt[c]), 20'(f[c][9:6]));
        chkPort(20'(cyc[c]),
                20'((FILT_BASE_NS + FILT_STEP_NS * f[c][9:6]) / CLK_NS));
      end
    end
    pulse(3);
    chkReg(OFS_CFG12, 20'h00000);
    tally_and_finish();
  end
endmodule : temp_id_and_wheel_sensor_test_regs_test
`default_nettype wire
